// *** nvs_arr_model.sv ***
// behavioural eeprom array and completion timer behind nvs_seq.
// assumes one arr_start per operation; done comes lat cycles later.
`default_nettype none
`include "nvs_defs.vh"
module nvs_arr_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        arr_start,
  input  wire logic [2:0]  arr_op,
  input  wire logic [23:0] arr_addr,
  input  wire logic [2:0]  arr_size_log2,
  input  wire logic [7:0]  arr_wdata,
  input  wire logic        arr_incl_eeprom,
  input  wire logic [7:0]  lat,
  output var  logic        arr_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ee [0:511];
  logic [7:0] cnt_q;
  logic [8:0] a;
  assign a = arr_addr[8:0];
  // reset drops the count, so an aborted write never reports done
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_q    <= 8'h00;
      arr_done <= 1'b0;
    end
    else
    begin
      arr_done <= (cnt_q == 8'h01);
      if (arr_start)
        cnt_q <= lat;
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
    end
  always @(posedge pclk)
    if (arr_start)
      for (int i = 0; i < 512; i++)
        if (arr_op == `NVS_OP_EE_ALL || (arr_op == `NVS_OP_CHIP &&
            arr_incl_eeprom) || (arr_op == `NVS_OP_EE_ERASE &&
            (i >> arr_size_log2) == (a >> arr_size_log2)))
          ee[i] <= 8'hff;
        else if (i == a && arr_op == `NVS_OP_EE_ERWR)
          ee[i] <= arr_wdata;
        else if (i == a && arr_op == `NVS_OP_EE_WRITE)
          ee[i] <= ee[i] & arr_wdata; // program only clears bits
endmodule // nvs_arr_model
`default_nettype wire

// *** nvs_defs.vh ***
// constants for the nonvolatile erase/write sequencer: register byte
// addresses, command codes, field positions, reset values and timing.
// assumes a 32-bit apb slave with each register in one aligned word.
`ifndef NVS_DEFS_VH
`define NVS_DEFS_VH

// register indices and byte addresses (index times four)
`define NVS_IDX_CMD      8'h00
`define NVS_IDX_PROT     8'h01
`define NVS_IDX_STATUS   8'h02
`define NVS_IDX_INTEN    8'h03
`define NVS_IDX_INTFLAG  8'h04
`define NVS_IDX_DATA     8'h06
`define NVS_IDX_ADDR     8'h08
`define NVS_IDX_KEY      8'h0a
`define NVS_A_CMD        8'h00
`define NVS_A_PROT       8'h04
`define NVS_A_STATUS     8'h08
`define NVS_A_INTEN      8'h0c
`define NVS_A_INTFLAG    8'h10
`define NVS_A_DATA       8'h18
`define NVS_A_ADDR       8'h20
`define NVS_A_KEY        8'h28

// command values
`define NVS_NO_COMMAND   7'h00
`define NVS_NO_OPERATION 7'h01
`define NVS_FL_WRITE     7'h02
`define NVS_FL_PAGE_ER   7'h08
`define NVS_FL_MP_LO     7'h09
`define NVS_FL_MP_HI     7'h0d
`define NVS_EE_WRITE     7'h12
`define NVS_EE_ERWR      7'h13
`define NVS_EE_BYTE_ER   7'h18
`define NVS_EE_MB_LO     7'h19
`define NVS_EE_MB_HI     7'h1d
`define NVS_CHIP_ER      7'h20
`define NVS_EE_ALL_ER    7'h30

// operation codes towards the memory arrays
`define NVS_OP_FL_WRITE  3'h0
`define NVS_OP_FL_ERASE  3'h1
`define NVS_OP_EE_WRITE  3'h2
`define NVS_OP_EE_ERWR   3'h3
`define NVS_OP_EE_ERASE  3'h4
`define NVS_OP_CHIP      3'h5
`define NVS_OP_EE_ALL    3'h6

// unlock keys and error codes
`define NVS_KEY_CMD      8'h9d
`define NVS_KEY_PROT     8'hd8
`define NVS_ERR_NONE     3'h0
`define NVS_ERR_COLLIDE  3'h4

// field positions and reset values
`define NVS_PROT_MAPLOCK 7
`define NVS_PROT_DATAWP  2
`define NVS_PROT_BOOT_READ_PROTECT  1
`define NVS_PROT_CODEWP  0
`define NVS_PROT_RESET   8'h30
`define NVS_ST_EEBUSY    1
`define NVS_ST_FLBUSY    0

// key window: four instructions, one per cycle at 10 mhz
`define NVS_KEY_WIN_INSTR 4
`define NVS_CLK_MHZ       10
`define NVS_KEY_WIN_CYC   3'd4

`endif

// *** nvs_seq.v ***
// nonvolatile erase/write sequencer: command register, store decode,
// array operation launch, busy tracking, ready flag and sleep control.
// assumes the arrays pulse arr_done once per started operation and that
// the cpu holds mem_req and its address steady while mem_wait is high.
//
// The register offsets and the APB register port were chosen for this implementation.
`default_nettype none
`include "nvs_defs.vh"

module nvs_seq #(
  parameter AW        = 24,
  parameter PAGE_BITS = 9
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  input  wire          dbg_port_active,
  input  wire          dev_locked,
  input  wire          eeprom_preserve_fuse,
  input  wire          bod_fuse_en,
  input  wire          mem_req,
  input  wire          mem_we,
  input  wire          mem_is_eeprom,
  input  wire [AW-1:0] mem_addr,
  input  wire [7:0]    mem_wdata,
  output wire          mem_wait,
  output wire          cpu_halt,
  output reg           arr_start,
  output reg  [2:0]    arr_op,
  output reg  [AW-1:0] arr_addr,
  output reg  [2:0]    arr_size_log2,
  output reg  [7:0]    arr_wdata,
  output reg           arr_incl_eeprom,
  input  wire          arr_done,
  output wire          irq,
  input  wire          sleep_req,
  input  wire          sleep_idle,
  output wire          nvm_clk_keep,
  output wire          nvm_asleep,
  output wire          wake_req,
  output wire          bod_keep_on
);

  // store decode: {valid, is_eeprom, op[2:0], size_log2[2:0]}
  function [7:0] st_decode;
    input [6:0] c;
    begin
      st_decode = 8'h00;
      case (c)
        `NVS_FL_WRITE:   st_decode = {2'b10, `NVS_OP_FL_WRITE, 3'd0};
        `NVS_FL_PAGE_ER: st_decode = {2'b10, `NVS_OP_FL_ERASE, 3'd0};
        `NVS_EE_WRITE:   st_decode = {2'b11, `NVS_OP_EE_WRITE, 3'd0};
        `NVS_EE_ERWR:    st_decode = {2'b11, `NVS_OP_EE_ERWR, 3'd0};
        `NVS_EE_BYTE_ER: st_decode = {2'b11, `NVS_OP_EE_ERASE, 3'd0};
        default:
        begin
          if (c >= `NVS_FL_MP_LO && c <= `NVS_FL_MP_HI)
            st_decode = {2'b10, `NVS_OP_FL_ERASE, c[2:0]};
          else if (c >= `NVS_EE_MB_LO && c <= `NVS_EE_MB_HI)
            st_decode = {2'b11, `NVS_OP_EE_ERASE, c[2:0]};
        end
      endcase
    end
  endfunction

  function addr_hit;
    input [7:0] a;
    begin
      case (a)
        `NVS_A_CMD, `NVS_A_PROT, `NVS_A_STATUS, `NVS_A_INTEN,
        `NVS_A_INTFLAG, `NVS_A_DATA, `NVS_A_ADDR, `NVS_A_KEY:
          addr_hit = 1'b1;
        default:
          addr_hit = 1'b0;
      endcase
    end
  endfunction

  // no command and no operation both leave the controller idle
  function is_idle;
    input [6:0] c;
    begin
      is_idle = (c == `NVS_NO_COMMAND) || (c == `NVS_NO_OPERATION);
    end
  endfunction

  // write strobe for one register word
  function reg_wr;
    input       w;
    input [7:0] a;
    input [7:0] r;
    begin
      reg_wr = w && (a == r);
    end
  endfunction

  reg  [6:0]    cmd_q;
  reg  [7:0]    prot_q;
  reg  [2:0]    err_q;
  reg           ie_q;
  reg           rdy_q;
  reg  [15:0]   data_q;
  reg  [AW-1:0] addr_q;
  reg  [7:0]    key_q;
  reg  [2:0]    win_q;
  reg           ee_busy_q;
  reg           fl_busy_q;
  reg           halt_q;
  reg  [31:0]   rdata_d;

  wire          busy = ee_busy_q | fl_busy_q;
  wire          setup = psel & ~penable;
  wire          wr = psel & penable & pwrite & addr_hit(paddr);
  wire          cmd_unlock = (win_q != 3'd0) &&
                             (key_q == `NVS_KEY_CMD);
  wire          prot_unlock = (win_q != 3'd0) &&
                              (key_q == `NVS_KEY_PROT);
  wire [6:0]    new_cmd = pwdata[6:0];
  wire          cur_idle = is_idle(cmd_q);
  wire          new_idle = is_idle(new_cmd);
  wire          cmd_wr = reg_wr(wr, paddr, `NVS_A_CMD) && cmd_unlock;
  wire          collide = cmd_wr && !new_idle && !cur_idle &&
                          (new_cmd != cmd_q);
  wire          chip_go = cmd_wr && cur_idle && !busy &&
                          (new_cmd == `NVS_CHIP_ER) &&
                          dbg_port_active;
  wire          eeall_go = cmd_wr && cur_idle && !busy &&
                           (new_cmd == `NVS_EE_ALL_ER);
  wire          cmd_go = chip_go | eeall_go;
  wire [7:0]    dec = st_decode(cmd_q);
  wire          st_take = mem_req && mem_we && !busy && !cmd_go;
  wire          st_go = st_take && dec[7] && (dec[6] == mem_is_eeprom);
  wire [3:0]    sh = {1'b0, dec[2:0]} +
                     (dec[6] ? 4'd0 : PAGE_BITS[3:0]);
  wire [AW-1:0] st_mask = {AW{1'b1}} << sh;
  wire          ee_incl = !eeprom_preserve_fuse | dev_locked;
  wire          ee_done = arr_done & ee_busy_q;
  wire          rdy_clr = reg_wr(wr, paddr, `NVS_A_INTFLAG) && pwdata[0];
  wire          prot_wr = reg_wr(wr, paddr, `NVS_A_PROT);
  wire [7:0]    prot_d;
  genvar        g;

  // apb: zero wait states, read data captured during the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit(paddr);

  // read mux; the word is registered in the setup cycle and then stands
  // through the access phase, so the slave never needs a wait state
  always @*
  begin
    case (paddr)
      `NVS_A_CMD:     rdata_d = {25'h0, cmd_q};
      `NVS_A_PROT:    rdata_d = {24'h0, prot_q};
      `NVS_A_STATUS:  rdata_d = {25'h0, err_q, 2'b00,
                                 ee_busy_q, fl_busy_q};
      `NVS_A_INTEN:   rdata_d = {31'h0, ie_q};
      `NVS_A_INTFLAG: rdata_d = {31'h0, rdy_q};
      `NVS_A_DATA:    rdata_d = {16'h0, data_q};
      `NVS_A_ADDR:    rdata_d = {{(32-AW){1'b0}}, addr_q};
      `NVS_A_KEY:     rdata_d = {24'h0, key_q};
      default:        rdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rdata_d;
  end

  // key window opens on a key write and closes four cycles later
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_q <= 8'h00;
      win_q <= 3'd0;
    end
    else if (reg_wr(wr, paddr, `NVS_A_KEY))
    begin
      key_q <= pwdata[7:0];
      win_q <= `NVS_KEY_WIN_CYC;
    end
    else if (win_q != 3'd0)
      win_q <= win_q - 3'd1;
  end

  // command register; chip and eeprom erase fall back to no command
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_q <= `NVS_NO_COMMAND;
    else if (cmd_wr && !collide)
    begin
      if (new_idle || st_decode(new_cmd) != 8'h00)
        cmd_q <= new_cmd;
      else if (cmd_go)
        cmd_q <= new_cmd;
    end
    else if (arr_done && (cmd_q == `NVS_CHIP_ER ||
                          cmd_q == `NVS_EE_ALL_ER))
      cmd_q <= `NVS_NO_COMMAND;
  end

  // error field: a new collision wins over a software clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_q <= `NVS_ERR_NONE;
    else if (collide)
      err_q <= `NVS_ERR_COLLIDE;
    else if (reg_wr(wr, paddr, `NVS_A_STATUS))
      err_q <= pwdata[6:4];
  end

  // protection map: keyed bits are set-only, so only a reset clears them
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_prot
      if (g == `NVS_PROT_MAPLOCK || g == `NVS_PROT_DATAWP ||
          g == `NVS_PROT_BOOT_READ_PROTECT || g == `NVS_PROT_CODEWP)
      begin : g_keyed
        assign prot_d[g] = prot_q[g] |
                           (prot_wr && prot_unlock && pwdata[g]);
      end
      else if (g == 4 || g == 5)
      begin : g_map
        // map field is not keyed; the old lock bit freezes it
        assign prot_d[g] = (prot_wr && !prot_q[`NVS_PROT_MAPLOCK]) ?
                           pwdata[g] : prot_q[g];
      end
      else
      begin : g_rsvd
        assign prot_d[g] = 1'b0;
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prot_q <= `NVS_PROT_RESET;
    else
      prot_q <= prot_d;
  end

  // interrupt enable and ready flag; completion wins over the clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ie_q  <= 1'b0;
      rdy_q <= 1'b0;
    end
    else
    begin
      if (reg_wr(wr, paddr, `NVS_A_INTEN))
        ie_q <= pwdata[0];
      if (ee_done)
        rdy_q <= 1'b1;
      else if (rdy_clr)
        rdy_q <= 1'b0;
    end
  end

  // launch and busy tracking; reset drops busy and start, which aborts
  // any operation in flight on the array side
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arr_start       <= 1'b0;
      arr_op          <= `NVS_OP_FL_WRITE;
      arr_addr        <= {AW{1'b0}};
      arr_size_log2   <= 3'd0;
      arr_wdata       <= 8'h00;
      arr_incl_eeprom <= 1'b0;
      ee_busy_q       <= 1'b0;
      fl_busy_q       <= 1'b0;
      halt_q          <= 1'b0;
      data_q          <= 16'h0000;
      addr_q          <= {AW{1'b0}};
    end
    else
    begin
      arr_start <= 1'b0;
      if (chip_go)
      begin
        // protection bits are not consulted here
        arr_start       <= 1'b1;
        arr_op          <= `NVS_OP_CHIP;
        arr_addr        <= {AW{1'b0}};
        arr_size_log2   <= 3'd0;
        arr_wdata       <= 8'hff;
        arr_incl_eeprom <= ee_incl;
        fl_busy_q       <= 1'b1;
        ee_busy_q       <= ee_incl;
        halt_q          <= 1'b1;
      end
      else if (eeall_go)
      begin
        arr_start       <= 1'b1;
        arr_op          <= `NVS_OP_EE_ALL;
        arr_addr        <= {AW{1'b0}};
        arr_size_log2   <= 3'd0;
        arr_wdata       <= 8'hff;
        arr_incl_eeprom <= 1'b1;
        ee_busy_q       <= 1'b1;
        halt_q          <= 1'b1;
      end
      else if (st_go)
      begin
        arr_start       <= 1'b1;
        arr_op          <= dec[5:3];
        arr_addr        <= mem_addr & st_mask;
        arr_size_log2   <= dec[2:0];
        // eeprom erase modes store ones whatever the cpu wrote
        arr_wdata       <= (dec[5:3] == `NVS_OP_EE_ERASE) ?
                           8'hff : mem_wdata;
        arr_incl_eeprom <= dec[6];
        ee_busy_q       <= dec[6];
        fl_busy_q       <= ~dec[6];
        // flash work halts the cpu; eeprom work lets it run on
        halt_q          <= ~dec[6];
        data_q          <= {8'h00, mem_wdata};
        addr_q          <= mem_addr;
      end
      else if (arr_done)
      begin
        ee_busy_q <= 1'b0;
        fl_busy_q <= 1'b0;
        halt_q    <= 1'b0;
      end
    end
  end

  // any access while busy stalls the bus until the array finishes
  assign mem_wait = mem_req & (busy | cmd_go);
  assign cpu_halt = halt_q;

  assign irq      = ie_q & rdy_q;
  // deeper sleep modes keep the ready interrupt from waking the core
  assign wake_req = irq & sleep_req & sleep_idle;

  // clocks stay on through sleep only while eeprom work is pending
  assign nvm_clk_keep = ~sleep_req | ee_busy_q;
  assign nvm_asleep   = sleep_req & ~ee_busy_q;

  // fuses are never addressed, so the fused detector stays as set
  assign bod_keep_on = bod_fuse_en;

endmodule // nvs_seq

`default_nettype wire

// *** nvs_seq_sva.sv ***
// checker for nvs_seq: launch fields, bus wait, chip erase, sleep.
// assumes it is bound to nvs_seq; one clock pclk, reset presetn.
`default_nettype none
`include "nvs_defs.vh"
module nvs_seq_chk #(
  parameter AW        = 24,
  parameter PAGE_BITS = 9
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          dbg_port_active,
  input wire logic          dev_locked,
  input wire logic          eeprom_preserve_fuse,
  input wire logic          mem_req,
  input wire logic          mem_wait,
  input wire logic          cpu_halt,
  input wire logic          arr_start,
  input wire logic [2:0]    arr_op,
  input wire logic [AW-1:0] arr_addr,
  input wire logic [2:0]    arr_size_log2,
  input wire logic [7:0]    arr_wdata,
  input wire logic          arr_incl_eeprom,
  input wire logic          irq,
  input wire logic          sleep_req,
  input wire logic          sleep_idle,
  input wire logic          nvm_clk_keep,
  input wire logic          nvm_asleep,
  input wire logic          wake_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // busy is already set in the cycle of an eeprom launch
  sequence s_ee_go;
    arr_start && arr_op inside {`NVS_OP_EE_WRITE, `NVS_OP_EE_ERWR,
                                `NVS_OP_EE_ERASE, `NVS_OP_EE_ALL};
  endsequence
  sequence s_chip_go;
    arr_start && arr_op == `NVS_OP_CHIP;
  endsequence
  sequence s_ee_erase;
    arr_start && arr_op == `NVS_OP_EE_ERASE;
  endsequence
  a_one_launch: assert property (arr_start |=> !arr_start)
    else $error("launch pulse longer than one cycle");
  a_ee_stall: assert property (s_ee_go ##1 mem_req |-> mem_wait)
    else $error("no bus wait during eeprom operation");
  a_erase_ones: assert property (s_ee_erase |-> arr_wdata == 8'hff)
    else $error("erase data not all ones");
  a_group_align: assert property (s_ee_erase |->
    (arr_addr & ~({AW{1'b1}} << arr_size_log2)) == '0)
    else $error("eeprom group address not aligned");
  a_page_align: assert property (arr_start &&
    arr_op == `NVS_OP_FL_ERASE |->
    (arr_addr & ~({AW{1'b1}} << (arr_size_log2 + PAGE_BITS))) == '0)
    else $error("flash group address not aligned");
  a_chip_port: assert property (s_chip_go |-> $past(dbg_port_active))
    else $error("chip erase launched from the cpu");
  a_chip_eeprom: assert property (s_chip_go |->
    arr_incl_eeprom == (dev_locked || !eeprom_preserve_fuse))
    else $error("chip erase eeprom selection wrong");
  a_eeall_halt: assert property (arr_start &&
    arr_op == `NVS_OP_EE_ALL |-> ##[0:1] cpu_halt)
    else $error("cpu not halted in eeprom erase");
  a_sleep_keep: assert property (s_ee_go ##0 sleep_req |->
    nvm_clk_keep && !nvm_asleep)
    else $error("clocks dropped during eeprom operation");
  a_wake_idle: assert property (wake_req |-> sleep_idle && irq)
    else $error("wake outside idle sleep");
endmodule // nvs_seq_chk
`default_nettype wire

// *** test_nvm_erase_write_sequencer.sv ***
// testbench: apb and cpu-side stimulus for nvs_seq with array model.
// assumes the design, the model and the checker are compiled first.
`default_nettype none
`include "nvs_defs.vh"
module test_nvm_erase_write_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, mem_wdata, arr_wdata, lat;
  logic [31:0] pwdata, prdata, q;
  logic        dbg_port_active, dev_locked, eeprom_preserve_fuse;
  logic        bod_fuse_en, mem_req, mem_we, mem_is_eeprom, mem_wait;
  logic [23:0] mem_addr, arr_addr;
  logic [2:0]  arr_op, arr_size_log2;
  logic        cpu_halt, arr_start, arr_incl_eeprom, arr_done, irq;
  logic        sleep_req, sleep_idle, nvm_clk_keep, nvm_asleep;
  logic        wake_req, bod_keep_on, waited;
  int          fails = 0;
  int          tests_run = 0;
  nvs_seq DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .dbg_port_active, .dev_locked,
    .eeprom_preserve_fuse, .bod_fuse_en, .mem_req, .mem_we, .mem_is_eeprom,
    .mem_addr, .mem_wdata, .mem_wait, .cpu_halt, .arr_start, .arr_op,
    .arr_addr, .arr_size_log2, .arr_wdata, .arr_incl_eeprom, .arr_done,
    .irq, .sleep_req, .sleep_idle, .nvm_clk_keep, .nvm_asleep, .wake_req,
    .bod_keep_on);
  nvs_arr_model arr (.pclk, .presetn, .arr_start, .arr_op, .arr_addr,
    .arr_size_log2, .arr_wdata, .arr_incl_eeprom, .lat, .arr_done);
  always #50 pclk = ~pclk;
  initial
  begin
    repeat (100000) @(posedge pclk);
    hang();
  end
  task automatic conclude;
    $display("compares %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hang;
    fails++;
    conclude();
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
      hang();
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic cmd(input logic [6:0] c);
    apb(1'b1, `NVS_A_KEY, {24'h0, `NVS_KEY_CMD});
    apb(1'b1, `NVS_A_CMD, {25'h0, c});
  endtask
  task automatic mode(input logic [6:0] c);
    cmd(`NVS_NO_COMMAND);
    cmd(c);
  endtask
  task automatic idle;
    int n;
    for (n = 0; n < 300; n++)
    begin
      apb(1'b0, `NVS_A_STATUS, 32'h0);
      if (q[1:0] === 2'b00)
        break;
    end
    if (n == 300)
      hang();
  endtask
  task automatic st(input logic ee, input logic [23:0] a,
                    input logic [7:0] d);
    int n;
    @(posedge pclk);
    mem_req       <= 1'b1;
    mem_is_eeprom <= ee;
    mem_addr      <= a;
    mem_wdata     <= d;
    for (n = 0; n < 300; n++)
    begin
      @(posedge pclk);
      if (mem_wait === 1'b0)
        break;
      waited = 1'b1;
    end
    if (n == 300)
      hang();
    mem_req <= 1'b0;
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, mem_req} = '0;
    {dbg_port_active, dev_locked, eeprom_preserve_fuse, sleep_req} = '0;
    {mem_is_eeprom, mem_addr, mem_wdata, sleep_idle} = '0;
    {bod_fuse_en, mem_we, waited, lat} = {3'b110, 8'd3};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rc(`NVS_A_PROT, 32'h30);
    rc(`NVS_A_CMD, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(err), 32'h1);
    chk(32'(bod_keep_on), 32'h1);
    bod_fuse_en <= 1'b0;
    @(negedge pclk);
    chk(32'(bod_keep_on), 32'h0);
    @(posedge pclk);
    bod_fuse_en <= 1'b1;
    apb(1'b1, `NVS_A_CMD, 32'h12);
    rc(`NVS_A_CMD, 32'h0);
    cmd(`NVS_EE_WRITE);
    rc(`NVS_A_CMD, 32'h12);
    apb(1'b1, `NVS_A_KEY, {24'h0, `NVS_KEY_PROT});
    apb(1'b1, `NVS_A_PROT, 32'h37);
    rc(`NVS_A_PROT, 32'h37);
    apb(1'b1, `NVS_A_PROT, 32'hb7);
    rc(`NVS_A_PROT, 32'h37);
    cmd(`NVS_EE_BYTE_ER);
    rc(`NVS_A_CMD, 32'h12);
    rc(`NVS_A_STATUS, 32'h40);
    apb(1'b1, `NVS_A_STATUS, 32'h0);
    apb(1'b1, `NVS_A_INTEN, 32'h1);
    mode(`NVS_EE_ERWR);
    st(1'b1, 24'h5, 8'h3c);
    waited = 1'b0;
    st(1'b1, 24'h6, 8'ha5);
    chk(32'(waited), 32'h1);
    idle();
    chk(32'(arr.ee[5]), 32'h3c);
    chk(32'(arr.ee[6]), 32'ha5);
    chk(32'(irq), 32'h1);
    apb(1'b1, `NVS_A_INTFLAG, 32'h1);
    @(negedge pclk);
    chk(32'(irq), 32'h0);
    mode(`NVS_EE_BYTE_ER);
    st(1'b1, 24'h5, 8'h00);
    idle();
    chk(32'(arr.ee[5]), 32'hff);
    chk(32'(arr.ee[6]), 32'ha5);
    mode(`NVS_EE_WRITE);
    st(1'b1, 24'h5, 8'h81);
    idle();
    chk(32'(arr.ee[5]), 32'h81);
    for (int k = 1; k < 6; k++)
    begin
      mode(7'(24 + k));
      st(1'b1, 24'h137, 8'h00);
      idle();
      chk(32'(arr_size_log2), 32'(k));
      chk(32'(arr_addr), 32'h137 & ~((32'h1 << k) - 1));
      mode(7'(8 + k));
      st(1'b0, 24'h12345, 8'h00);
      idle();
      chk(32'(arr_op), 32'(`NVS_OP_FL_ERASE));
      chk(32'(arr_size_log2), 32'(k));
      chk(32'(arr_addr), 32'h12345 & ~((32'h1 << (k + 9)) - 1));
    end
    mode(`NVS_EE_ERWR);
    lat        <= 8'd40;
    sleep_req  <= 1'b1;
    sleep_idle <= 1'b1;
    st(1'b1, 24'h7, 8'h11);
    @(negedge pclk);
    chk(32'(nvm_clk_keep), 32'h1);
    chk(32'(nvm_asleep), 32'h0);
    rc(`NVS_A_STATUS, 32'h2);
    mem_we <= 1'b0;
    waited = 1'b0;
    st(1'b1, 24'h7, 8'h00);
    chk(32'(waited), 32'h1);
    mem_we <= 1'b1;
    idle();
    @(negedge pclk);
    chk(32'(nvm_asleep), 32'h1);
    chk(32'(wake_req), 32'h1);
    @(posedge pclk);
    sleep_idle <= 1'b0;
    @(negedge pclk);
    chk(32'(wake_req), 32'h0);
    cmd(`NVS_NO_COMMAND);
    sleep_req <= 1'b0;
    cmd(`NVS_CHIP_ER);
    rc(`NVS_A_CMD, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      dev_locked           <= (i == 1);
      eeprom_preserve_fuse <= (i < 2);
      dbg_port_active      <= 1'b1;
      cmd(`NVS_CHIP_ER);
      idle();
      chk(32'(arr_op), 32'(`NVS_OP_CHIP));
      chk(32'(arr_incl_eeprom), 32'(i != 0));
      chk(32'(arr.ee[6]), i == 0 ? 32'ha5 : 32'hff);
      rc(`NVS_A_CMD, 32'h0);
    end
    dbg_port_active <= 1'b0;
    mode(`NVS_EE_ERWR);
    st(1'b1, 24'h7, 8'h42);
    idle();
    cmd(`NVS_NO_COMMAND);
    cmd(`NVS_EE_ALL_ER);
    repeat (2) @(negedge pclk);
    chk(32'(cpu_halt), 32'h1);
    idle();
    chk(32'(arr.ee[7]), 32'hff);
    mode(`NVS_EE_WRITE);
    st(1'b1, 24'h8, 8'h00);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rc(`NVS_A_STATUS, 32'h0);
    rc(`NVS_A_CMD, 32'h0);
    conclude();
  end
endmodule // test_nvm_erase_write_sequencer
bind nvs_seq nvs_seq_chk #(.AW(AW), .PAGE_BITS(PAGE_BITS)) chk (.pclk,
  .presetn, .dbg_port_active, .dev_locked, .eeprom_preserve_fuse,
  .mem_req, .mem_wait, .cpu_halt, .arr_start, .arr_op, .arr_addr,
  .arr_size_log2, .arr_wdata, .arr_incl_eeprom, .irq, .sleep_req,
  .sleep_idle, .nvm_clk_keep, .nvm_asleep, .wake_req);
`default_nettype wire
